/* File: rtl/suc_consts.svh */
// constants of the serial port: register offsets, field positions, resets, counts
// assumes inclusion by bare name from the rtl files of this block
`ifndef SUC_CONSTS_SVH
`define SUC_CONSTS_SVH
// =====================================================================
// register offsets on the plain register port
`define SUC_ADDR_CONTROL   3'h0
`define SUC_ADDR_BUFFER    3'h1
`define SUC_ADDR_POWER     3'h2
`define SUC_ADDR_CONFIG    3'h3
`define SUC_ADDR_T1_RELOAD 3'h4
`define SUC_ADDR_T2_LOW    3'h5
`define SUC_ADDR_T2_HIGH   3'h6
// =====================================================================
// field positions of serial_control
`define SUC_RX_DONE   0
`define SUC_TX_DONE   1
`define SUC_RX_NINTH  2
`define SUC_TX_NINTH  3
`define SUC_RX_ENABLE 4
`define SUC_MULTIPROC 5
`define SUC_MODE_LSB  6
// field positions of power_control and the configuration register
`define SUC_BAUD_DOUBLER   7
`define SUC_CFG_IRQ_EN     0
`define SUC_CFG_T1_SEL_LSB 1
`define SUC_CFG_TX_T2      4
`define SUC_CFG_RX_T2      5
// =====================================================================
// reset values
`define SUC_BYTE_RESET   8'h00
`define SUC_RELOAD_RESET 16'h0000
// =====================================================================
// timing counts in system clocks or oversample ticks
`define SUC_MODE0_LAST  4'hb
`define SUC_MODE0_HALF  4'h5
`define SUC_T1_PRE_LAST 4'hb
`define SUC_OVS_LAST    4'hf
`define SUC_START_CHECK 4'h7
`define SUC_FIX_SLOW    2'h3
`define SUC_FIX_FAST    2'h1
`endif

/* File: rtl/suc_pkg.sv */
// types of the serial port: modes and one-hot state codes
// assumes nothing beyond a SystemVerilog compiler
package suc_pkg;
  typedef enum logic [1:0] {
    SUC_MODE0 = 2'h0,
    SUC_MODE1 = 2'h1,
    SUC_MODE2 = 2'h2,
    SUC_MODE3 = 2'h3
  } suc_mode_type;
  typedef enum logic [3:0] {
    TX_IDLE  = 4'h1,
    TX_START = 4'h2,
    TX_DATA  = 4'h4,
    TX_STOP  = 4'h8
  } suc_tx_state_type;
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } suc_rx_state_type;
  typedef enum logic [2:0] {
    S0_IDLE  = 3'h1,
    S0_SHIFT = 3'h2,
    S0_DONE  = 3'h4
  } suc_sync_state_type;
endpackage

/* File: rtl/suc_pin_sync.sv */
// three-stage synchroniser for a pin; the level follows once stages two and three agree
// assumes an asynchronous input and the block clock ref_clk
`timescale 1ns/10ps
module suc_pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // pin and filtered level
  input  wire logic pinIn,
  output logic      level
);
  logic stage1;
  logic stage2;
  logic stage3;
  // =====================================================================
  // stage one is read only by stage two
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage1 <= RESET_LEVEL;
      stage2 <= RESET_LEVEL;
      stage3 <= RESET_LEVEL;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end
  // a change counts only when the last two stages agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      level <= RESET_LEVEL;
    end else if (stage2 == stage3) begin
      level <= stage3;
    end
  end
endmodule

/* File: rtl/suc_baud_gen.sv */
// baud sources: timer 1 auto-reload, timer 2 baud generator, fixed mode 2 divider
// outputs are one-cycle ticks at sixteen times the bit rate
`timescale 1ns/10ps
`include "suc_consts.svh"
module suc_baud_gen
  import suc_pkg::*;
(
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // configuration
  input  wire suc_mode_type mode,
  input  wire logic         baudDoubler,
  input  wire logic [1:0]   t1ClkSel,
  input  wire logic         t1ExtLevel,
  input  wire logic [7:0]   t1Reload,
  input  wire logic [15:0]  t2Reload,
  input  wire logic         txT2Sel,
  input  wire logic         rxT2Sel,
  // oversample ticks
  output logic              txTick,
  output logic              rxTick
);
  logic [3:0]  preCnt;
  logic [7:0]  t1Cnt;
  logic        t1Half;
  logic        extPrev;
  logic        t2Phase;
  logic [15:0] t2Cnt;
  logic [1:0]  fixCnt;
  logic        t1Step;
  logic        t1Ovf;
  logic        t1Tick;
  logic        t2Ovf;
  logic        fixTick;
  // =====================================================================
  // timer 1 clock: system clock, system clock over twelve, or external edge
  assign t1Step = (t1ClkSel == 2'h0) ? 1'b1 :
                  (t1ClkSel == 2'h1) ? (preCnt == `SUC_T1_PRE_LAST) :
                  (t1ClkSel == 2'h2) ? (t1ExtLevel & ~extPrev) : 1'b0;
  assign t1Ovf  = t1Step && (t1Cnt == 8'hff);
  // without the doubler every second overflow counts, giving one over thirty-two
  assign t1Tick = t1Ovf && (baudDoubler || t1Half);
  assign t2Ovf  = t2Phase && (t2Cnt == 16'hffff);
  assign fixTick = (fixCnt == (baudDoubler ? `SUC_FIX_FAST : `SUC_FIX_SLOW));
  // transmit and receive choose their sources separately
  assign txTick = (mode == SUC_MODE2) ? fixTick : (txT2Sel ? t2Ovf : t1Tick);
  assign rxTick = (mode == SUC_MODE2) ? fixTick : (rxT2Sel ? t2Ovf : t1Tick);
  // timer 1 prescaler, counter and overflow halver
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      preCnt  <= 4'h0;
      t1Cnt   <= 8'h00;
      t1Half  <= 1'b0;
      extPrev <= 1'b0;
    end else begin
      preCnt  <= (preCnt == `SUC_T1_PRE_LAST) ? 4'h0 : preCnt + 4'h1;
      extPrev <= t1ExtLevel;
      if (t1Ovf) begin
        t1Cnt  <= t1Reload;
        t1Half <= ~t1Half;
      end else if (t1Step) begin
        t1Cnt <= t1Cnt + 8'h01;
      end
    end
  end
  // timer 2 always runs as baud generator at half the system clock
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      t2Phase <= 1'b0;
      t2Cnt   <= `SUC_RELOAD_RESET;
    end else begin
      t2Phase <= ~t2Phase;
      if (t2Ovf) begin
        t2Cnt <= t2Reload;
      end else if (t2Phase) begin
        t2Cnt <= t2Cnt + 16'h0001;
      end
    end
  end
  // fixed divider for mode 2: tick every two or four clocks
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fixCnt <= 2'h0;
    end else begin
      fixCnt <= fixTick ? 2'h0 : fixCnt + 2'h1;
    end
  end
endmodule

/* File: rtl/suc_serial_port.sv */
// serial port with synchronous mode 0 and asynchronous modes 1 to 3
// assumes a register master on ref_clk and one-cycle strobes; pins are asynchronous
// Summary of operation
// - received bytes move into a separate holding register
// - buffer read gives receive data, write transmits
// - control bit 1 transmit done, bit 0 receive done
// - done flags stay set until software clears
// - mode field selects one of four framings
// - mode 0 master: data on rx, clock on tx
// - mode 0 write shifts eight bits LSB first
// - mode 0 receive needs enable, flag clear; halts
// - mode 0 shift clock is system clock/12
// - mode 1 frame: start, eight data, stop
// - mode 1 transmit done at stop bit start
// - mode 1 accept needs flag clear; stop bit checked only with multiproc
// - accept stores byte, ninth, flag; reject nothing
// - interrupt request when enabled and flag set
// - timer rollover gives one baud logic clock
// - doubler picks 1/16 or 1/32 timer 1 rate
// - timer 1 clock: system, /12 or external
// - timer 2 select forces baud generator, no irq
// - nine-bit modes carry ninth bit both ways
// - mode 2 rate system clock /64 or /32
// - mode 3 is mode 2 with timer rate
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`include "suc_consts.svh"
module suc_serial_port
  import suc_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // register port
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrStrobe,
  input  wire logic       regRdStrobe,
  output logic      [7:0] regRdData,
  // serial pins
  input  wire logic       rxIn,
  output logic            rxOut,
  output logic            rxOe,
  output logic            txPin,
  input  wire logic       t1ExtPin,
  // system signals
  output logic            serialIrq,
  output logic            timer2IrqOff
);
  suc_mode_type       mode;
  suc_tx_state_type   txState;
  suc_rx_state_type   rxState;
  suc_sync_state_type m0State;
  logic rxDone, txDone, rxNinth, txNinth, rxEnable, multiproc;
  logic baudDoubler, irqEnable, txT2Sel, rxT2Sel;
  logic [1:0]  t1ClkSel;
  logic [7:0]  t1Reload;
  logic [15:0] t2Reload;
  logic [7:0]  rxBuffer;
  logic        rxLevel, t1ExtLevel, rxPrev, txTick, rxTick;
  logic        txLine, m0Tx, m0Clk;
  logic [8:0]  txShift;
  logic [8:0]  rxShift;
  logic [3:0]  txCnt, rxCnt, txBit, rxBit, m0Phase;
  logic [2:0]  m0Bit;
  logic [7:0]  m0Shift;
  logic        wrCtrl, wrBuf, nineBit, asyncTiSet, m0TxEnd, m0RxLoad;
  logic        rxFinish, rxNinthSample, accept;
  logic [7:0]  rxData;
  logic [3:0]  lastBit;
  // =====================================================================
  // pin synchronisers and baud sources
  suc_pin_sync #(.RESET_LEVEL(1'b1)) u_rx_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pinIn   (rxIn),
    .level   (rxLevel)
  );
  suc_pin_sync #(.RESET_LEVEL(1'b0)) u_t1_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pinIn   (t1ExtPin),
    .level   (t1ExtLevel)
  );
  suc_baud_gen u_baud (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .mode        (mode),
    .baudDoubler (baudDoubler),
    .t1ClkSel    (t1ClkSel),
    .t1ExtLevel  (t1ExtLevel),
    .t1Reload    (t1Reload),
    .t2Reload    (t2Reload),
    .txT2Sel     (txT2Sel),
    .rxT2Sel     (rxT2Sel),
    .txTick      (txTick),
    .rxTick      (rxTick)
  );
  // =====================================================================
  // decode and shared terms
  assign wrCtrl  = regWrStrobe && (regAddr == `SUC_ADDR_CONTROL);
  assign wrBuf   = regWrStrobe && (regAddr == `SUC_ADDR_BUFFER);
  assign nineBit = mode[1];
  assign lastBit = nineBit ? 4'h8 : 4'h7;
  assign serialIrq    = irqEnable && (txDone || rxDone);
  assign timer2IrqOff = txT2Sel || rxT2Sel;
  // the shift clock owns the tx pin while mode 0 runs
  assign txPin = (m0State != S0_IDLE) ? m0Clk : txLine;
  assign rxOe  = (m0State == S0_SHIFT) && m0Tx;
  // plain control fields written by software
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode <= SUC_MODE0;
      {txNinth, rxEnable, multiproc} <= 3'h0;
      {baudDoubler, irqEnable, txT2Sel, rxT2Sel} <= 4'h0;
      t1ClkSel <= 2'h0;
      t1Reload <= `SUC_BYTE_RESET;
      t2Reload <= `SUC_RELOAD_RESET;
    end else if (regWrStrobe) begin
      case (regAddr)
        `SUC_ADDR_CONTROL: begin
          mode      <= suc_mode_type'(regWrData[`SUC_MODE_LSB+:2]);
          txNinth   <= regWrData[`SUC_TX_NINTH];
          rxEnable  <= regWrData[`SUC_RX_ENABLE];
          multiproc <= regWrData[`SUC_MULTIPROC];
        end
        `SUC_ADDR_POWER: baudDoubler <= regWrData[`SUC_BAUD_DOUBLER];
        `SUC_ADDR_CONFIG: begin
          irqEnable <= regWrData[`SUC_CFG_IRQ_EN];
          t1ClkSel  <= regWrData[`SUC_CFG_T1_SEL_LSB+:2];
          txT2Sel   <= regWrData[`SUC_CFG_TX_T2];
          rxT2Sel   <= regWrData[`SUC_CFG_RX_T2];
        end
        `SUC_ADDR_T1_RELOAD: t1Reload <= regWrData;
        `SUC_ADDR_T2_LOW: t2Reload[7:0] <= regWrData;
        `SUC_ADDR_T2_HIGH: t2Reload[15:8] <= regWrData;
        default: t1Reload <= t1Reload;
      endcase
    end
  end
  // done flags: hardware sets, only software clears, a set beats a clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txDone <= 1'b0;
      rxDone <= 1'b0;
    end else begin
      txDone <= (asyncTiSet || m0TxEnd) || (wrCtrl ? regWrData[`SUC_TX_DONE] : txDone);
      rxDone <= (accept || m0RxLoad) || (wrCtrl ? regWrData[`SUC_RX_DONE] : rxDone);
    end
  end
  // holding register keeps the last byte while the shifter takes the next
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxBuffer <= `SUC_BYTE_RESET;
      rxNinth  <= 1'b0;
    end else if (accept) begin
      rxBuffer <= rxData;
      rxNinth  <= rxNinthSample;
    end else if (m0RxLoad) begin
      rxBuffer <= m0Shift;
    end else if (wrCtrl) begin
      rxNinth <= regWrData[`SUC_RX_NINTH];
    end
  end
  // read data stand for the one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk) begin
    if (rst || !regRdStrobe) begin
      regRdData <= 8'h00;
    end else begin
      case (regAddr)
        `SUC_ADDR_CONTROL: regRdData <= {mode, multiproc, rxEnable, txNinth, rxNinth,
                                         txDone, rxDone};
        `SUC_ADDR_BUFFER: regRdData <= rxBuffer;
        `SUC_ADDR_POWER: regRdData <= {baudDoubler, 7'h00};
        `SUC_ADDR_CONFIG: regRdData <= {2'h0, rxT2Sel, txT2Sel, 1'b0, t1ClkSel, irqEnable};
        `SUC_ADDR_T1_RELOAD: regRdData <= t1Reload;
        `SUC_ADDR_T2_LOW: regRdData <= t2Reload[7:0];
        `SUC_ADDR_T2_HIGH: regRdData <= t2Reload[15:8];
        default: regRdData <= 8'h00;
      endcase
    end
  end
  // =====================================================================
  // asynchronous transmitter, sixteen ticks per bit
  assign asyncTiSet = (txState == TX_DATA) && txTick && (txCnt == `SUC_OVS_LAST) &&
                      (txBit == lastBit);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txState <= TX_IDLE;
      txLine  <= 1'b1;
      txShift <= 9'h000;
      txCnt   <= 4'h0;
      txBit   <= 4'h0;
    end else begin
      if (txTick) begin
        txCnt <= txCnt + 4'h1;
      end
      case (txState)
        TX_IDLE: begin
          txLine <= 1'b1;
          // writes while a frame runs are dropped so a frame is never torn
          if (wrBuf && (mode != SUC_MODE0)) begin
            txShift <= {txNinth, regWrData};
            txState <= TX_START;
            txLine  <= 1'b0;
            txCnt   <= 4'h0;
          end
        end
        TX_START: begin
          if (txTick && (txCnt == `SUC_OVS_LAST)) begin
            txState <= TX_DATA;
            txLine  <= txShift[0];
            txBit   <= 4'h0;
          end
        end
        TX_DATA: begin
          if (txTick && (txCnt == `SUC_OVS_LAST)) begin
            txShift <= {1'b0, txShift[8:1]};
            txBit   <= txBit + 4'h1;
            if (txBit == lastBit) begin
              txState <= TX_STOP;
              txLine  <= 1'b1;
            end else begin
              txLine <= txShift[1];
            end
          end
        end
        TX_STOP: begin
          if (txTick && (txCnt == `SUC_OVS_LAST)) begin
            txState <= TX_IDLE;
          end
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end
  // =====================================================================
  // asynchronous receiver: start edge, check at mid start bit, then mid bits
  assign rxFinish = (rxState == RX_STOP) && rxTick && (rxCnt == `SUC_OVS_LAST);
  assign rxNinthSample = nineBit ? rxShift[8] : rxLevel;
  assign rxData = nineBit ? rxShift[7:0] : rxShift[8:1];
  assign accept = rxFinish && !rxDone && (!multiproc || rxNinthSample);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rxState <= RX_IDLE;
      rxPrev  <= 1'b1;
      rxShift <= 9'h000;
      rxCnt   <= 4'h0;
      rxBit   <= 4'h0;
    end else begin
      rxPrev <= rxLevel;
      if (rxTick) begin
        rxCnt <= rxCnt + 4'h1;
      end
      case (rxState)
        RX_IDLE: begin
          if (rxEnable && (mode != SUC_MODE0) && rxPrev && !rxLevel) begin
            rxState <= RX_START;
            rxCnt   <= 4'h0;
          end
        end
        RX_START: begin
          if (rxTick && (rxCnt == `SUC_START_CHECK)) begin
            // a glitch that is gone by mid start bit is not a frame
            rxState <= rxLevel ? RX_IDLE : RX_DATA;
            rxCnt   <= 4'h0;
            rxBit   <= 4'h0;
          end
        end
        RX_DATA: begin
          if (rxTick && (rxCnt == `SUC_OVS_LAST)) begin
            rxShift <= {rxLevel, rxShift[8:1]};
            rxBit   <= rxBit + 4'h1;
            if (rxBit == lastBit) begin
              rxState <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rxFinish) begin
            rxState <= RX_IDLE;
          end
        end
        default: rxState <= RX_IDLE;
      endcase
    end
  end
  // =====================================================================
  // mode 0 shift engine: twelve clocks per bit, clock low then high
  assign m0TxEnd  = (m0State == S0_SHIFT) && m0Tx && (m0Phase == `SUC_MODE0_LAST) &&
                    (m0Bit == 3'h7);
  assign m0RxLoad = (m0State == S0_DONE);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      m0State <= S0_IDLE;
      m0Tx    <= 1'b0;
      m0Clk   <= 1'b1;
      m0Phase <= 4'h0;
      m0Bit   <= 3'h0;
      m0Shift <= 8'h00;
      rxOut   <= 1'b1;
    end else begin
      case (m0State)
        S0_IDLE: begin
          m0Clk   <= 1'b1;
          m0Phase <= 4'h0;
          m0Bit   <= 3'h0;
          if ((mode == SUC_MODE0) && wrBuf) begin
            m0Tx    <= 1'b1;
            m0Shift <= regWrData;
            rxOut   <= regWrData[0];
            m0Clk   <= 1'b0;
            m0State <= S0_SHIFT;
          end else if ((mode == SUC_MODE0) && rxEnable && !rxDone) begin
            m0Tx    <= 1'b0;
            m0Clk   <= 1'b0;
            m0State <= S0_SHIFT;
          end
        end
        S0_SHIFT: begin
          m0Phase <= (m0Phase == `SUC_MODE0_LAST) ? 4'h0 : m0Phase + 4'h1;
          if (m0Phase == `SUC_MODE0_HALF) begin
            m0Clk <= 1'b1;
            if (!m0Tx) begin
              m0Shift <= {rxLevel, m0Shift[7:1]};
            end
          end
          if (m0Phase == `SUC_MODE0_LAST) begin
            m0Bit <= m0Bit + 3'h1;
            if (m0Tx) begin
              m0Shift <= {1'b0, m0Shift[7:1]};
              rxOut   <= m0Shift[1];
            end
            if (m0Bit == 3'h7) begin
              m0State <= m0Tx ? S0_IDLE : S0_DONE;
            end else begin
              m0Clk <= 1'b0;
            end
          end
        end
        S0_DONE: m0State <= S0_IDLE;
        default: m0State <= S0_IDLE;
      endcase
    end
  end
  // =====================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_clockLow;
    !txPin [*6];
  endsequence
  sequence s_clockHigh;
    txPin [*6];
  endsequence
  property p_flagSetWins;
    (asyncTiSet || m0TxEnd) |=> txDone;
  endproperty
  a_flagSetWins: assert property (p_flagSetWins) else $error("tx done lost");
  property p_flagSticky;
    (rxDone && !wrCtrl) |=> rxDone;
  endproperty
  a_flagSticky: assert property (p_flagSticky) else $error("rx done cleared");
  property p_readBuffer;
    (regRdStrobe && (regAddr == `SUC_ADDR_BUFFER)) |=> (regRdData == $past(rxBuffer));
  endproperty
  a_readBuffer: assert property (p_readBuffer) else $error("bad buffer read");
  property p_rejectKeeps;
    (rxFinish && !accept) |=> (rxBuffer == $past(rxBuffer)) && (rxDone == $past(rxDone));
  endproperty
  a_rejectKeeps: assert property (p_rejectKeeps) else $error("reject changed");
  property p_acceptLoads;
    accept |=> rxDone && (rxBuffer == $past(rxData)) && (rxNinth == $past(rxNinthSample));
  endproperty
  a_acceptLoads: assert property (p_acceptLoads) else $error("accept lost");
  property p_shiftClock;
    ((m0State == S0_SHIFT) && (m0Phase == 4'h0)) |-> s_clockLow ##1 s_clockHigh;
  endproperty
  a_shiftClock: assert property (p_shiftClock) else $error("bad shift clock");
  property p_m0RxDone;
    ((m0State == S0_SHIFT) && !m0Tx && (m0Bit == 3'h7) && (m0Phase == 4'hb)) |=> ##1 rxDone;
  endproperty
  a_m0RxDone: assert property (p_m0RxDone) else $error("mode 0 rx flag");
  property p_tiAtStop;
    ((txState == TX_STOP) && ($past(txState) == TX_DATA)) |-> txDone && txPin;
  endproperty
  a_tiAtStop: assert property (p_tiAtStop) else $error("tx done late");
  property p_startBit;
    ((txState == TX_IDLE) && wrBuf && (mode != SUC_MODE0)) |=> !txPin && (txState == TX_START);
  endproperty
  a_startBit: assert property (p_startBit) else $error("no start bit");
  property p_irq;
    ($rose(rxDone) && irqEnable) |-> serialIrq;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt");
endmodule

/* File: verification/suc_far_uart.sv */
// far-side serial device: async frame source and mode 0 shift register
// assumes frames are started right after a rising edge of ref_clk
`timescale 1ns/10ps
module suc_far_uart (
  // clock
  input  wire logic       ref_clk,
  // line toward the port receive pin
  output logic            lineOut,
  // mode 0 shift clock and data from the port
  input  wire logic       shiftClk,
  input  wire logic       shiftData,
  output logic      [7:0] capByte
);
  // =====================================================
  // async source; line rests high between frames
  initial lineOut = 1'b1;
  task automatic sendFrame(input logic [10:0] bits, input int n, input int bt);
    for (int i = 0; i < n; i++) begin
      lineOut <= bits[i];
      repeat (bt) @(posedge ref_clk);
    end
    lineOut <= 1'b1;
  endtask
  // mode 0 source: a new bit at each falling shift clock, line high again after
  task automatic shiftByte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(negedge shiftClk);
      lineOut <= b[i];
    end
    @(posedge shiftClk);
    lineOut <= 1'b1;
  endtask
  // lsb arrives first, so it ends up in bit 0
  always @(posedge shiftClk) capByte <= {shiftData, capByte[7:1]};
endmodule

/* File: verification/tb_suc_serial_port.sv */
// bench for the serial port: register rows, then async and mode 0 frames
// assumes one 125 MHz clock; the far side is modelled by suc_far_uart
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errCount++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module tb_suc_serial_port;
  logic       ref_clk, rst, regWrStrobe, regRdStrobe, txPin, rxOut, rxOe;
  logic       serialIrq, t2Off, farLine;
  logic [2:0] regAddr;
  logic [7:0] regWrData, regRdData, capByte, rdv;
  int         errCount, comparisons;
  // rows: offset, write value, value read back
  logic [18:0] rows [5] = '{{3'h2, 8'h80, 8'h80}, {3'h2, 8'h00, 8'h00},
    {3'h7, 8'hff, 8'h00}, {3'h0, 8'h20, 8'h20}, {3'h0, 8'h00, 8'h00}};
  // shared receive pin: port drives it only in mode 0 transmit
  wire logic  rxLine = rxOe ? rxOut : farLine;
  suc_serial_port dut_u (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
    .regRdData(regRdData), .rxIn(rxLine), .rxOut(rxOut), .rxOe(rxOe), .txPin(txPin),
    .t1ExtPin(1'b0), .serialIrq(serialIrq), .timer2IrqOff(t2Off));
  suc_far_uart far_u (.ref_clk(ref_clk), .lineOut(farLine), .shiftClk(txPin),
    .shiftData(rxLine), .capByte(capByte));
  // =====================================================
  // clock and bus tasks
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {regAddr, regWrData, regWrStrobe} <= {a, d, 1'b1};
    @(posedge ref_clk);
    regWrStrobe <= 1'b0;
    // let the write settle so callers never look at flops in their launch step
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge ref_clk);
    {regAddr, regRdStrobe} <= {a, 1'b1};
    @(posedge ref_clk);
    regRdStrobe <= 1'b0;
    #1 rdv = regRdData;
  endtask
  // samples each bit near its middle; tolerates the short first start bit
  task automatic chkTx(input logic [10:0] bits, input int n, input int bt);
    int w;
    w = 0;
    while (txPin !== 1'b0 && w < 200) begin
      @(posedge ref_clk);
      w++;
    end
    repeat (bt / 2) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      #1 `CHK(txPin, bits[i])
      if (i == n - 1) `CHK(serialIrq, 1'b1)
      repeat (bt) @(posedge ref_clk);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // watchdog: the frames below need well under 10000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    errCount++;
    tally_and_finish();
  end
  // =====================================================
  // main sequence
  initial begin
    {rst, regWrStrobe, regRdStrobe, regAddr, regWrData} = '0;
    rst = 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rd(3'h0);
    `CHK(rdv, 8'h00)
    rd(3'h2);
    `CHK(rdv, 8'h00)
    `CHK({txPin, serialIrq}, 2'b10)
    for (int i = 0; i < 5; i++) begin
      wr(rows[i][18:16], rows[i][15:8]);
      rd(rows[i][18:16]);
      `CHK(rdv, rows[i][7:0])
    end
    wr(3'h3, 8'h11);
    `CHK(t2Off, 1'b1)
    wr(3'h3, 8'h01);
    // reload early: the counter must have wrapped once before frames rely on it
    wr(3'h4, 8'hff);
    $display("test registers done");
    // mode 2, ninth bit from control, 64 clocks a bit
    wr(3'h0, 8'h88);
    wr(3'h1, 8'ha5);
    chkTx({2'b11, 8'ha5, 1'b0}, 11, 64);
    repeat (100) @(posedge ref_clk);
    rd(3'h0);
    `CHK(rdv, 8'h8a)
    wr(3'h0, 8'h88);
    #1 `CHK(serialIrq, 1'b0)
    // mode 1 from timer 1 at reload ff with doubler: 16 clocks a bit
    wr(3'h2, 8'h80);
    wr(3'h0, 8'h40);
    wr(3'h1, 8'h5a);
    chkTx({2'b11, 8'h5a, 1'b0}, 10, 16);
    wr(3'h2, 8'h00);
    // mode 3 on timer 1 without doubler: every second overflow, 32 clocks a bit
    wr(3'h0, 8'hc8);
    wr(3'h1, 8'h3c);
    chkTx({2'b11, 8'h3c, 1'b0}, 11, 32);
    $display("test transmit done");
    // mode 2 receive: accept, then refused while flag set, then address filter
    wr(3'h0, 8'h90);
    far_u.sendFrame({2'b11, 8'h3c, 1'b0}, 11, 64);
    repeat (8) @(posedge ref_clk);
    rd(3'h1);
    `CHK(rdv, 8'h3c)
    rd(3'h0);
    `CHK(rdv, 8'h95)
    far_u.sendFrame({2'b11, 8'h55, 1'b0}, 11, 64);
    repeat (8) @(posedge ref_clk);
    rd(3'h1);
    `CHK(rdv, 8'h3c)
    wr(3'h0, 8'hb0);
    far_u.sendFrame({2'b10, 8'h66, 1'b0}, 11, 64);
    repeat (8) @(posedge ref_clk);
    rd(3'h0);
    `CHK(rdv, 8'hb0)
    far_u.sendFrame({2'b11, 8'h81, 1'b0}, 11, 64);
    repeat (8) @(posedge ref_clk);
    rd(3'h1);
    `CHK(rdv, 8'h81)
    `CHK(serialIrq, 1'b1)
    $display("test receive done");
    // mode 0 transmit: shift clock low 6, high 6, data on the receive pin
    wr(3'h0, 8'h00);
    wr(3'h1, 8'h96);
    repeat (3) @(posedge ref_clk);
    #1 `CHK(txPin, 1'b0)
    `CHK(rxOe, 1'b1)
    repeat (6) @(posedge ref_clk);
    #1 `CHK(txPin, 1'b1)
    repeat (6) @(posedge ref_clk);
    #1 `CHK(txPin, 1'b0)
    repeat (100) @(posedge ref_clk);
    `CHK(capByte, 8'h96)
    `CHK(rxOe, 1'b0)
    rd(3'h0);
    `CHK(rdv, 8'h02)
    // mode 0 receive: far side puts each bit out at the falling shift clock
    wr(3'h0, 8'h10);
    far_u.shiftByte(8'h4d);
    repeat (20) @(posedge ref_clk);
    rd(3'h1);
    `CHK(rdv, 8'h4d)
    rd(3'h0);
    `CHK(rdv, 8'h11)
    `CHK(txPin, 1'b1)
    $display("test mode 0 done");
    tally_and_finish();
  end
endmodule
